/* eeprom_consts.vh */
// constants for the serial eeprom instruction block
`ifndef EEPROM_CONSTS_VH
`define EEPROM_CONSTS_VH
`define CMD_WRITE_ENABLE  8'h06
`define CMD_WRITE_DISABLE 8'h04
`define CMD_STATUS_READ   8'h05
`define CMD_STATUS_WRITE  8'h01
`define CMD_ARRAY_READ    8'h03
`define CMD_ARRAY_WRITE   8'h02
`define SR_WIP            0
`define SR_WEL            1
`define SR_BP_LO          2
`define SR_BP_HI          3
`define SR_LOCK           7
`define ERASED_BYTE       8'hff
`define PAGE_BYTES        32
`define PROG_TIME_NS      5000000
`define CLK_PERIOD_NS     5
`define PROG_CYCLES       (`PROG_TIME_NS / `CLK_PERIOD_NS)
`endif

/* pin_sync.v */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
   parameter RESET_VAL = 1'b0
) (
   // clock and reset
   input  wire core_clk,
   input  wire reset_n,
   // level in and out
   input  wire pin_in,
   output reg  pin_out
);
   reg stage;
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         stage   <= RESET_VAL;
         pin_out <= RESET_VAL;
      end else begin
         stage   <= pin_in;
         pin_out <= stage;
      end
   end
endmodule

/* prog_timer.v */
// self-timed programming cycle counter
`timescale 1ns/1ps
module prog_timer #(
   parameter CYCLES = 1000000
) (
   // clock and reset
   input  wire core_clk,
   input  wire reset_n,
   // control
   input  wire start,
   output reg  busy,
   output reg  done
);
   reg [23:0] count;
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= 24'h000000;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            busy  <= 1'b1;
            count <= CYCLES[23:0] - 24'h000001;
         end else if (busy) begin
            if (count == 24'h000000) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               count <= count - 24'h000001;
            end
         end
      end
   end
endmodule

/* spi_eeprom_core.v */
// serial eeprom instruction decode, protection and array access
// Notes on behaviour
// - status write needs latch set earlier
// - status bits 6..4,1,0 unaffected; 6..4 zero
// - select must rise right after last bit
// - status programming starts at select rise
// - busy flag during cycle; end clears latch
// - status readable while programming runs
// - new protect bits apply at completion
// - lock 0: pin ignored; lock 1: pin high
// - locked mode entered in either order
// - locked mode left only by pin high
// - address width follows array size
// - read shifts out bytes, address increments
// - read address wraps to zero
// - select rise ends read at any bit
// - read ignored while programming
// - write: code, address, data; cycle at end
// - in-page address wrap, one page cycle
// - reject write on latch, busy, boundary, protect
// - power-up: latch and busy clear
// - delivered array ff, protect bits zero
// - one-byte command codes
// - unknown code deselects the device
// - protect field picks read-only region
`timescale 1ns/1ps
`include "eeprom_consts.vh"
module spi_eeprom_core #(
   parameter ADDR_BITS   = 13,
   parameter PROG_CYCLES = `PROG_CYCLES
) (
   // clock and reset
   input  wire core_clk,
   input  wire reset_n,
   // spi pins
   input  wire select_n,
   input  wire serial_clk,
   input  wire serial_in,
   input  wire write_protect_n,
   output reg  serial_out,
   output reg  serial_out_en,
   // status view
   output reg  write_in_progress,
   output reg  write_enable_latch,
   output reg  hardware_locked_mode
);
   localparam DEPTH = 1 << ADDR_BITS;
   localparam PAGE_BITS = 5;
   localparam ST_CMD   = 3'h0;
   localparam ST_ADDR  = 3'h1;
   localparam ST_RDATA = 3'h2;
   localparam ST_WDATA = 3'h3;
   localparam ST_SRW   = 3'h4;
   localparam ST_SRR   = 3'h5;
   localparam ST_WAIT  = 3'h6;
   localparam ST_IDLE  = 3'h7;

   reg [7:0]           mem [0:DEPTH-1];
   reg [7:0]           page_buf [0:`PAGE_BYTES-1];
   reg [`PAGE_BYTES-1:0] page_mask;
   reg [ADDR_BITS-1:0] page_base;
   reg [PAGE_BITS-1:0] pg_ptr;
   reg [PAGE_BITS:0]   pg_idx;
   reg                 prog_array;

   wire sel_s;
   wire clk_s;
   wire din_s;
   wire wp_s;
   reg  clk_d;
   reg  sel_d;
   reg  [2:0]  state;
   reg  [2:0]  bit_cnt;
   reg  [7:0]  shift;
   reg  [15:0] addr_sh;
   reg  [ADDR_BITS-1:0] addr;
   reg  [7:0]  out_byte;
   reg  [7:0]  cmd;
   reg         addr_hi_done;
   reg         byte_end;
   reg         data_seen;
   reg         srw_ok;
   reg  [7:0]  sr_new;
   reg         lock_bit;
   reg  [1:0]  block_protect;
   reg         start_sr;
   reg         start_arr;
   reg         sr_prog;
   wire        busy;
   wire        done;
   wire        rise = clk_s && !clk_d;
   wire        fall = !clk_s && clk_d;
   wire        sel_rise = sel_s && !sel_d;
   wire [7:0]  next_shift = {shift[6:0], din_s};
   wire [7:0]  status_byte = {lock_bit, 3'b000, block_protect[1],
                              block_protect[0], write_enable_latch,
                              write_in_progress};
   wire [ADDR_BITS-1:0] next_addr = addr + {{(ADDR_BITS-1){1'b0}}, 1'b1};
   integer i;

   // protected region test on a page address
   function prot_hit;
      input [1:0] bp;
      input [ADDR_BITS-1:0] a;
      begin
         case (bp)
            2'b00:   prot_hit = 1'b0;
            2'b01:   prot_hit = &a[ADDR_BITS-1:ADDR_BITS-2];
            2'b10:   prot_hit = a[ADDR_BITS-1];
            default: prot_hit = 1'b1;
         endcase
      end
   endfunction

   pin_sync #(.RESET_VAL(1'b1)) u_sel (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .pin_in   (select_n),
      .pin_out  (sel_s)
   );
   pin_sync #(.RESET_VAL(1'b0)) u_clk (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .pin_in   (serial_clk),
      .pin_out  (clk_s)
   );
   pin_sync #(.RESET_VAL(1'b0)) u_din (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .pin_in   (serial_in),
      .pin_out  (din_s)
   );
   pin_sync #(.RESET_VAL(1'b1)) u_wp (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .pin_in   (write_protect_n),
      .pin_out  (wp_s)
   );
   prog_timer #(.CYCLES(PROG_CYCLES)) u_timer (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .start    (start_sr | start_arr),
      .busy     (busy),
      .done     (done)
   );

   // delivery contents
   initial begin
      for (i = 0; i < DEPTH; i = i + 1)
         mem[i] = `ERASED_BYTE;
   end

   // array programming: masked bytes of one page at completion
   always @(posedge core_clk) begin
      if (done && prog_array) begin
         for (i = 0; i < `PAGE_BYTES; i = i + 1)
            if (page_mask[i])
               mem[page_base + i[ADDR_BITS-1:0]] <= page_buf[i];
      end
      // a refused write during a cycle must not touch the page in flight
      if (state == ST_WDATA && rise && bit_cnt == 3'h7 && !busy)
         page_buf[pg_ptr] <= next_shift;
   end

   // out byte fetched from array when address settles
   always @(posedge core_clk) begin
      out_byte <= mem[addr];
   end

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         clk_d <= 1'b0;
         sel_d <= 1'b1;
         state <= ST_IDLE;
         bit_cnt <= 3'h0;
         shift <= 8'h00;
         addr_sh <= 16'h0000;
         addr <= {ADDR_BITS{1'b0}};
         cmd <= 8'h00;
         addr_hi_done <= 1'b0;
         byte_end <= 1'b0;
         data_seen <= 1'b0;
         srw_ok <= 1'b0;
         sr_new <= 8'h00;
         lock_bit <= 1'b0;
         block_protect <= 2'b00;
         write_enable_latch <= 1'b0;
         write_in_progress <= 1'b0;
         hardware_locked_mode <= 1'b0;
         serial_out <= 1'b0;
         serial_out_en <= 1'b0;
         start_sr <= 1'b0;
         start_arr <= 1'b0;
         sr_prog <= 1'b0;
         prog_array <= 1'b0;
         page_mask <= {`PAGE_BYTES{1'b0}};
         page_base <= {ADDR_BITS{1'b0}};
         pg_ptr <= {PAGE_BITS{1'b0}};
         pg_idx <= {(PAGE_BITS+1){1'b0}};
      end else begin
         clk_d <= clk_s;
         sel_d <= sel_s;
         start_sr <= 1'b0;
         start_arr <= 1'b0;
         hardware_locked_mode <= lock_bit && !wp_s;
         write_in_progress <= busy;
         if (done) begin
            write_enable_latch <= 1'b0;
            prog_array <= 1'b0;
            if (sr_prog) begin
               lock_bit <= sr_new[`SR_LOCK];
               block_protect <= sr_new[3:2];
               sr_prog <= 1'b0;
            end
         end
         if (sel_s) begin
            // deselected: end any instruction, release output
            serial_out_en <= 1'b0;
            state <= ST_CMD;
            bit_cnt <= 3'h0;
            addr_hi_done <= 1'b0;
            data_seen <= 1'b0;
            if (sel_rise) begin
               if (state == ST_SRW && byte_end && srw_ok) begin
                  start_sr <= 1'b1;
                  sr_prog <= 1'b1;
               end
               if (state == ST_WDATA && byte_end && data_seen &&
                   write_enable_latch && !busy &&
                   !prot_hit(block_protect, page_base)) begin
                  start_arr <= 1'b1;
                  prog_array <= 1'b1;
               end
               if (state == ST_WAIT && cmd == `CMD_WRITE_ENABLE)
                  write_enable_latch <= 1'b1;
               if (state == ST_WAIT && cmd == `CMD_WRITE_DISABLE)
                  write_enable_latch <= 1'b0;
            end
         end else if (state == ST_IDLE) begin
            state <= ST_IDLE;
         end else if (rise) begin
            byte_end <= 1'b0;
            bit_cnt <= bit_cnt + 3'h1;
            shift <= next_shift;
            case (state)
               ST_CMD: begin
                  if (bit_cnt == 3'h7) begin
                     cmd <= next_shift;
                     byte_end <= 1'b1;
                     case (next_shift)
                        `CMD_WRITE_ENABLE, `CMD_WRITE_DISABLE:
                           state <= ST_WAIT;
                        `CMD_STATUS_READ: state <= ST_SRR;
                        `CMD_STATUS_WRITE: begin
                           state <= ST_SRW;
                           srw_ok <= write_enable_latch && !busy &&
                                     !(lock_bit && !wp_s);
                        end
                        `CMD_ARRAY_READ:
                           state <= busy ? ST_IDLE : ST_ADDR;
                        `CMD_ARRAY_WRITE: state <= ST_ADDR;
                        default: state <= ST_IDLE;
                     endcase
                  end
               end
               ST_ADDR: begin
                  if (bit_cnt == 3'h7) begin
                     addr_sh <= {addr_sh[7:0], next_shift};
                     addr_hi_done <= 1'b1;
                     if (addr_hi_done) begin
                        addr <= {addr_sh[ADDR_BITS-9:0],
                                 next_shift};
                        if (cmd == `CMD_ARRAY_READ) begin
                           state <= ST_RDATA;
                        end else begin
                           state <= ST_WDATA;
                           pg_idx <= {(PAGE_BITS+1){1'b0}};
                           if (!busy) begin
                              page_base <= {addr_sh[ADDR_BITS-9:0],
                                            next_shift[7:PAGE_BITS],
                                            {PAGE_BITS{1'b0}}};
                              pg_ptr <= next_shift[PAGE_BITS-1:0];
                              page_mask <= {`PAGE_BYTES{1'b0}};
                           end
                        end
                     end
                  end
               end
               ST_RDATA: begin
                  if (bit_cnt == 3'h7)
                     addr <= next_addr;
               end
               ST_WDATA: begin
                  if (bit_cnt == 3'h7) begin
                     byte_end <= 1'b1;
                     data_seen <= 1'b1;
                     if (!busy)
                        page_mask[pg_ptr] <= 1'b1;
                     pg_ptr <= pg_ptr + {{(PAGE_BITS-1){1'b0}}, 1'b1};
                     pg_idx <= pg_idx + {{PAGE_BITS{1'b0}}, 1'b1};
                  end
               end
               ST_SRW: begin
                  if (bit_cnt == 3'h7) begin
                     sr_new <= next_shift;
                     byte_end <= 1'b1;
                     state <= ST_WAIT;
                  end
               end
               default: begin
                  if (state == ST_WAIT && cmd == `CMD_STATUS_WRITE)
                     srw_ok <= 1'b0;
               end
            endcase
            if (state == ST_WAIT && cmd == `CMD_STATUS_WRITE)
               state <= ST_WAIT;
         end else if (fall) begin
            // drive output on falling edges
            if (state == ST_RDATA) begin
               serial_out_en <= 1'b1;
               serial_out <= out_byte[3'h7 - bit_cnt];
            end else if (state == ST_SRR) begin
               serial_out_en <= 1'b1;
               serial_out <= status_byte[3'h7 - bit_cnt];
            end
         end
         if (sel_rise && state == ST_WAIT && cmd == `CMD_STATUS_WRITE &&
             byte_end && srw_ok) begin
            start_sr <= 1'b1;
            sr_prog <= 1'b1;
         end
      end
   end
endmodule

/* spi_eeprom_monitor.sv */
// concurrent checks on the eeprom core ports
`timescale 1ns/1ps
module spi_eeprom_monitor #(
   parameter PROG_CYCLES = 50
) (
   // clock and reset
   input wire core_clk,
   input wire reset_n,
   // spi pins
   input wire select_n,
   input wire serial_clk,
   input wire serial_in,
   input wire write_protect_n,
   input wire serial_out,
   input wire serial_out_en,
   // status view
   input wire write_in_progress,
   input wire write_enable_latch,
   input wire hardware_locked_mode
);
   reg [31:0] busy_len;
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n)
         busy_len <= 32'h0;
      else if (write_in_progress)
         busy_len <= busy_len + 32'h1;
      else
         busy_len <= 32'h0;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence deselect_held;
      select_n [*6];
   endsequence
   sequence wp_released;
      write_protect_n [*5];
   endsequence
   prog_needs_latch_a: assert property (
      $rose(write_in_progress) |-> write_enable_latch)
      else $error("programming began without latch");
   prog_on_deselect_a: assert property (
      $rose(write_in_progress) |-> select_n && $past(select_n))
      else $error("programming began while selected");
   prog_length_a: assert property (
      $fell(write_in_progress) |-> busy_len >= PROG_CYCLES - 1)
      else $error("programming cycle too short");
   end_clears_latch_a: assert property (
      $fell(write_in_progress) |-> ##[0:2] !write_enable_latch)
      else $error("latch not cleared at completion");
   latch_on_deselect_a: assert property (
      $rose(write_enable_latch) |-> select_n)
      else $error("latch set while selected");
   release_out_a: assert property (
      deselect_held |-> !serial_out_en)
      else $error("output driven while deselected");
   lock_leave_a: assert property (
      wp_released |-> !hardware_locked_mode)
      else $error("locked mode kept with pin high");
   lock_entry_a: assert property (
      $rose(hardware_locked_mode) |->
         !write_protect_n && !$past(write_protect_n, 2))
      else $error("locked mode entered with pin high");
endmodule
bind spi_eeprom_core spi_eeprom_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_mon (
   .core_clk(core_clk), .reset_n(reset_n), .select_n(select_n),
   .serial_clk(serial_clk), .serial_in(serial_in),
   .write_protect_n(write_protect_n), .serial_out(serial_out),
   .serial_out_en(serial_out_en), .write_in_progress(write_in_progress),
   .write_enable_latch(write_enable_latch),
   .hardware_locked_mode(hardware_locked_mode));

/* spi_host_model.sv */
// spi host model driving the eeprom pins
`timescale 1ns/1ps
module spi_host_model (
   // clock
   input  wire core_clk,
   // spi pins
   output reg  select_n,
   output reg  serial_clk,
   output reg  serial_in,
   input  wire serial_out
);
   initial begin
      select_n = 1'b1;
      serial_clk = 1'b0;
      serial_in = 1'b0;
   end
   // up to eight bits, msb first, 130 ns per bit
   task automatic shift(input [7:0] d, input integer n, output [7:0] q);
      integer i;
      begin
         q = 8'h00;
         for (i = 7; i > 7 - n; i = i - 1) begin
            @(negedge core_clk) serial_in = d[i];
            repeat (12) @(negedge core_clk);
            serial_clk = 1'b1;
            q = {q[6:0], serial_out};
            repeat (13) @(negedge core_clk);
            serial_clk = 1'b0;
         end
      end
   endtask
   task automatic edge_sel(input v);
      begin
         @(negedge core_clk) select_n = v;
         if (v)
            serial_in = ~serial_in;
         repeat (12) @(negedge core_clk);
      end
   endtask
   // whole frame: nb bytes of tx, then xb stray bits
   task automatic frame(input [63:0] tx, input integer nb,
                        input integer xb, output [63:0] rx);
      integer k;
      reg [7:0] q;
      begin
         rx = 64'h0;
         edge_sel(1'b0);
         for (k = nb - 1; k >= 0; k = k - 1) begin
            shift(tx[8*k +: 8], 8, q);
            rx = {rx[55:0], q};
         end
         if (xb > 0)
            shift(8'h00, xb, q);
         edge_sel(1'b1);
      end
   endtask
endmodule

/* spi_eeprom_core_tb.sv */
// self-checking bench for the eeprom core
`timescale 1ns/1ps
module spi_eeprom_core_tb;
   reg         core_clk;
   reg         reset_n;
   reg         write_protect_n;
   wire        select_n;
   wire        serial_clk;
   wire        serial_in;
   wire        serial_out;
   wire        serial_out_en;
   wire        write_in_progress;
   wire        write_enable_latch;
   wire        hardware_locked_mode;
   integer     num_errors;
   integer     cmp_count;
   reg [63:0]  rx;
   integer     en_count;
   integer     en_base;
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n)
         en_count <= 0;
      else if (serial_out_en === 1'b1)
         en_count <= en_count + 1;
   end
   spi_host_model u_host (.core_clk(core_clk), .select_n(select_n),
      .serial_clk(serial_clk), .serial_in(serial_in),
      .serial_out(serial_out));
   spi_eeprom_core #(.ADDR_BITS(13), .PROG_CYCLES(2000)) u_dut (
      .core_clk(core_clk), .reset_n(reset_n), .select_n(select_n),
      .serial_clk(serial_clk), .serial_in(serial_in),
      .write_protect_n(write_protect_n), .serial_out(serial_out),
      .serial_out_en(serial_out_en),
      .write_in_progress(write_in_progress),
      .write_enable_latch(write_enable_latch),
      .hardware_locked_mode(hardware_locked_mode));
   task chk(input [63:0] got, input [63:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
         end
      end
   endtask
   task final_report;
      begin
         $display("compares %0d mismatches %0d", cmp_count, num_errors);
         if (num_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   task xf(input [63:0] tx, input integer nb, input integer xb);
      u_host.frame(tx, nb, xb, rx);
   endtask
   task wait_idle;
      integer n;
      begin
         n = 0;
         while (write_in_progress !== 1'b0 && n < 3000) begin
            @(negedge core_clk);
            n = n + 1;
         end
         if (n == 3000) begin
            num_errors = num_errors + 1;
            final_report;
         end
      end
   endtask
   initial begin
      num_errors = 0;
      cmp_count = 0;
      en_base = 0;
      write_protect_n = 1'b1;
      reset_n = 1'b0;
      repeat (2) @(negedge core_clk);
      reset_n = 1'b1;
      repeat (8) @(negedge core_clk);
      chk(write_in_progress, 0);
      chk(write_enable_latch, 0);
      xf(64'h02000055, 4, 0);
      chk(write_in_progress, 0);
      xf(64'h06, 1, 0);
      chk(write_enable_latch, 1);
      xf(64'h02fffea1a2a3, 6, 0);
      chk(write_in_progress, 1);
      en_base = en_count;
      xf(64'h03000000, 4, 0);
      chk(en_count - en_base, 0);
      wait_idle;
      chk(write_enable_latch, 0);
      $display("test array write done");
      xf(64'h03fffe00000000, 7, 0);
      chk(rx[31:0], 32'ha1a2ffff);
      xf(64'h031fe000, 4, 0);
      chk(rx[7:0], 8'ha3);
      xf(64'h031fe0, 3, 3);
      chk(serial_out_en, 0);
      $display("test array read done");
      xf(64'h06, 1, 0);
      xf(64'h01ff, 2, 0);
      chk(write_in_progress, 1);
      xf(64'h0500, 2, 0);
      chk(rx[7:0], 8'h03);
      wait_idle;
      xf(64'h0500, 2, 0);
      chk(rx[7:0], 8'h8c);
      $display("test status write done");
      @(negedge core_clk) write_protect_n = 1'b0;
      repeat (6) @(negedge core_clk);
      chk(hardware_locked_mode, 1);
      xf(64'h06, 1, 0);
      xf(64'h02010077, 4, 0);
      chk(write_in_progress, 0);
      xf(64'h06, 1, 0);
      xf(64'h0100, 2, 0);
      chk(write_in_progress, 0);
      @(negedge core_clk) write_protect_n = 1'b1;
      repeat (6) @(negedge core_clk);
      chk(hardware_locked_mode, 0);
      xf(64'h06, 1, 0);
      xf(64'h0100, 2, 1);
      chk(write_in_progress, 0);
      xf(64'h06, 1, 0);
      xf(64'h0100, 2, 0);
      chk(write_in_progress, 1);
      wait_idle;
      xf(64'h0500, 2, 0);
      chk(rx[7:0], 8'h00);
      $display("test protection done");
      en_base = en_count;
      xf(64'h07000000, 4, 0);
      chk(en_count - en_base, 0);
      $display("test unknown code done");
      final_report;
   end
endmodule
